// *** design/aad_action_decoder.sv ***
// action word decoder of the second-stage rule lookup, with AXI4-Lite registers
//
// Function
// R1: bits 1:0 select the time-protocol command
// R2: bits 3:2 select the delay insertion
// R3: bits 5:4 select sequence or delay-request handling
// R4: bit 5 set clears bits 5:4 downstream
// R5: bit 6 copies source MAC to destination
// R6: bit 7 loads egress port source MAC
// R7: hop limit flag decrements TTL or hop limit
// R8: swap sub-modes 4-7 preset TTL instead
// R9: loopback flag restricts mode to loopback frames
// R10: mode 8 with flag replaces leading DMAC bits
// R11: L4 rewrite loads ports from logical ID
// R12: CPU copies carry logical ID in header
// R13: hit index selects one of 4K counters
// R14: MAC swap flag swaps unless bit 5 set
// R15: routing mode bits enable routing updates
// R16: swap sub-modes 0-3 replace or swap MACs
// R17: sub-modes 4-5 add IP swapping
// R18: sub-modes 6-7 IP swap, sources of replacements
// R19: mode bits 3:2 equal 1 give control bits
// R20: domain selector passed to delay response builder
// R21: log interval is code, or code minus 8
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "aad_regs.svh"
module aad_action_decoder
    import aad_pkg::*;
#(
    parameter int CNT_N = 4096,
    parameter int SIP_N = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`AAD_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [`AAD_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic act_valid,
    input wire aad_action_t act,
    input wire aad_frame_t frm,
    output logic res_valid,
    output aad_result_t res
);
    localparam int CW = $clog2(CNT_N);
    localparam int SW = $clog2(SIP_N);

    generate
        if (CNT_N < 2 || CNT_N > 4096 || (1 << CW) != CNT_N) begin : g_chk_cnt
            $error("aad_action_decoder: CNT_N must be a power of 2 up to 4096");
        end
        if (SIP_N < 2 || SIP_N > 32 || (1 << SW) != SIP_N) begin : g_chk_sip
            $error("aad_action_decoder: SIP_N must be a power of 2 up to 32");
        end
    endgenerate

    // ==================================================================
    // register file state
    logic [31:0] ipsc_ff;
    logic [11:0] cidx_ff;
    logic [31:0] seen_ff;
    logic [31:0] sip_tbl [SIP_N];
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [31:0] cnt_rd;

    // ==================================================================
    // AXI4-Lite write side: address and data taken together
    wire wr_go = awvalid && wvalid && !bvalid_ff;
    wire [`AAD_AW-1:0] wa = awaddr;
    wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire wr_ipsc = wr_go && (wa == `AAD_IPSC_OFS);
    wire wr_cidx = wr_go && (wa == `AAD_CIDX_OFS);
    wire wr_cval = wr_go && (wa == `AAD_CVAL_OFS);
    wire wa_sip = wa[7] && (wa[1:0] == 2'h0) && ({1'b0, wa[6:2]} < 6'(SIP_N));
    wire wr_sip = wr_go && wa_sip;
    wire wr_hit = wr_ipsc || wr_cidx || wr_cval || wr_sip || (wa == `AAD_STAT_OFS);
    wire [SW-1:0] wsip_idx = wa[SW+1:2];
    wire [31:0] nxt_ipsc = ((ipsc_ff & ~wmask) | (wdata & wmask)) & `AAD_IPSC_MASK;
    wire [31:0] nxt_cidx = ({20'h0, cidx_ff} & ~wmask) | (wdata & wmask);

    assign awready = wr_go;
    assign wready = wr_go;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `AAD_RESP_OK;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? `AAD_RESP_OK : `AAD_RESP_ERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ipsc_ff <= `AAD_IPSC_RST;
            cidx_ff <= 12'h0;
        end else begin
            if (wr_ipsc) begin
                ipsc_ff <= nxt_ipsc;
            end
            if (wr_cidx) begin
                cidx_ff <= nxt_cidx[11:0];
            end
        end
    end

    // replacement source addresses, indexed by the policer index
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < SIP_N; i++) begin
                sip_tbl[i] <= 32'h0;
            end
        end else if (wr_sip) begin
            sip_tbl[wsip_idx] <= (sip_tbl[wsip_idx] & ~wmask) | (wdata & wmask);
        end
    end

    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    // ==================================================================
    // AXI4-Lite read side: one read in flight, data one cycle later
    wire rd_go = arvalid && !rvalid_ff;
    wire [`AAD_AW-1:0] ra = araddr;
    wire ra_sip = ra[7] && (ra[1:0] == 2'h0) && ({1'b0, ra[6:2]} < 6'(SIP_N));
    wire ra_ipsc = (ra == `AAD_IPSC_OFS);
    wire ra_cidx = (ra == `AAD_CIDX_OFS);
    wire ra_cval = (ra == `AAD_CVAL_OFS);
    wire ra_stat = (ra == `AAD_STAT_OFS);
    wire ra_hit = ra_sip || ra_ipsc || ra_cidx || ra_cval || ra_stat;
    wire [31:0] rd_word = ra_ipsc ? ipsc_ff :
                          ra_cidx ? {20'h0, cidx_ff} :
                          ra_cval ? cnt_rd :
                          ra_stat ? seen_ff :
                          ra_sip ? sip_tbl[ra[SW+1:2]] : 32'h0;

    assign arready = rd_go;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `AAD_RESP_OK;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= ra_hit ? `AAD_RESP_OK : `AAD_RESP_ERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // ==================================================================
    // frame counters
    aad_frame_counter_table #(.N(CNT_N), .AW(CW)) u_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .inc(act_valid),
        .inc_idx(act.hit_idx[CW-1:0]), // [R13]
        .clr(wr_cval),
        .clr_idx(cidx_ff[CW-1:0]),
        .rd_idx(cidx_ff[CW-1:0]),
        .rd_cnt(cnt_rd)
    );

    // ==================================================================
    // route/swap mode decode
    wire [7:0] rw = act.rw_cmd;
    wire [3:0] rtm = act.rt_mode;
    wire [2:0] sub = rtm[2:0];
    wire [6:0] ttl_bits = {1'b0, ipsc_ff[`AAD_BITS_LSB +: 6]};
    wire [7:0] ttl_val = ipsc_ff[`AAD_TTL_LSB +: 8];
    wire rt_gate = !act.lb_only || frm.lb_class; // [R9]
    // mode 8 with the flag set is the partial replace, not the gate
    wire dpart = (rtm == `AAD_RT_DPART) && act.lb_only; // [R10]
    wire rt_on = (rtm != 4'h0) && (rt_gate || dpart); // [R15]
    wire swp = rt_on && rtm[3];
    wire rtg = rt_on && !rtm[3];
    wire ctl_ovl = rt_on && (rtm[3:2] == 2'b01); // [R19]

    // ==================================================================
    // MAC address handling
    wire [47:0] d0 = rw[6] ? frm.smac : frm.dmac; // [R5]
    wire [47:0] s0 = rw[7] ? frm.egr_smac : frm.smac; // [R6]
    wire flag_sw = act.mac_swap && !rw[5]; // [R14]
    wire [47:0] d1 = flag_sw ? s0 : d0;
    wire [47:0] s1 = flag_sw ? d0 : s0;
    wire d_mc = d1[`AAD_MAC_MC];
    wire sub25 = (sub >= 3'h2) && (sub <= 3'h5);
    wire sub35 = (sub == 3'h3) || (sub == 3'h5);
    // the new source after a swap is the old destination, or the replacement MAC if the destination's group bit is set
    wire mac_sw = swp && ((sub == 3'h2) || (sub == 3'h4) || (sub35 && !d_mc)); // [R16]
    wire s_repl = swp && ((sub == 3'h1) || (sub == 3'h7) || (sub25 && d_mc)); // [R16]
    wire d_repl = swp && (sub == 3'h0); // [R16]
    wire [6:0] d_bits = dpart ? ttl_bits : 7'(`AAD_MAC_W); // [R10]
    wire [47:0] d_new;

    aad_mac_merge #(.W(`AAD_MAC_W)) u_merge (
        .orig(d1),
        .repl(act.repl_mac),
        .nbits(d_bits),
        .merged(d_new)
    );

    wire [47:0] nxt_dmac = d_repl ? d_new : (mac_sw ? s1 : d1);
    wire [47:0] nxt_smac = s_repl ? act.repl_mac : (mac_sw ? d1 : s1); // [R18]

    // ==================================================================
    // IP address and hop limit handling
    wire ip_mode = swp && sub[2];
    wire nxt_ipsw = ip_mode && !((sub == 3'h5) && frm.dip_mc); // [R17]
    wire nxt_siprep = ip_mode && frm.dip_mc; // [R18]
    wire [31:0] nxt_sip = sip_tbl[act.pol_idx[SW-1:0]]; // [R18]
    wire hop_set = act.hop_upd && ip_mode; // [R8]
    wire hop_dec = act.hop_upd && !ip_mode; // [R7]
    wire aad_hop_t nxt_hop = hop_set ? AAD_HOP_SET : (hop_dec ? AAD_HOP_DEC : AAD_HOP_NONE);

    // ==================================================================
    // rewrite command pass-on and result assembly
    wire [7:0] nxt_rw = rw[5] ? {rw[7:6], 2'b00, rw[3:0]} : rw; // [R4]
    aad_result_t nxt_res;

    always_comb begin
        nxt_res = '0;
        nxt_res.ptp_cmd = rw[1:0]; // [R1]
        nxt_res.dly_cmd = rw[3:2]; // [R2]
        nxt_res.seq_cmd = rw[5:4]; // [R3]
        nxt_res.rw_out = nxt_rw;
        nxt_res.dmac = nxt_dmac;
        nxt_res.smac = nxt_smac;
        nxt_res.ip_swap = nxt_ipsw;
        nxt_res.sip_repl = nxt_siprep;
        nxt_res.sip = nxt_sip;
        nxt_res.hop = nxt_hop;
        nxt_res.hop_val = ttl_val;
        nxt_res.uc_route = rtg && rtm[0]; // [R15]
        nxt_res.mc_route = rtg && rtm[1];
        nxt_res.mac_ovl = rtg && rtm[2];
        nxt_res.pt_ovr = ctl_ovl && act.repl_mac[0]; // [R19]
        nxt_res.pt_idx = ctl_ovl ? act.repl_mac[6:1] : 6'h0;
        nxt_res.dlb_en = ctl_ovl && act.repl_mac[16];
        nxt_res.dlb_idx = ctl_ovl ? act.repl_mac[26:17] : 10'h0;
        nxt_res.l4_rw = act.l4_rw;
        nxt_res.dport = act.l4_rw ? act.lid : 16'h0; // [R11]
        nxt_res.sport = act.l4_rw ? act.lid_mask : 16'h0; // [R11]
        nxt_res.cl_rslt = act.cpu_copy ? act.lid : 16'h0; // [R12]
        nxt_res.dom_sel = act.dom_sel; // [R20]
        nxt_res.log_vld = rw[5];
        // {flag, code} read as signed 4 bits is code, or code minus 8
        nxt_res.log_int = {act.mac_swap, act.log_code}; // [R21]
        nxt_res.hit_idx = act.hit_idx;
    end

    aad_result_t res_ff;
    logic res_valid_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_valid_ff <= 1'b0;
            res_ff <= '0;
            seen_ff <= 32'h0;
        end else begin
            res_valid_ff <= act_valid;
            if (act_valid) begin
                res_ff <= nxt_res;
                seen_ff <= seen_ff + 32'h1;
            end
        end
    end

    assign res_valid = res_valid_ff;
    assign res = res_ff;

    // ==================================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ptp_cmd: assert property (act_valid |=> res.ptp_cmd == $past(act.rw_cmd[1:0])) // [R1]
        else $error("ptp command not passed");
    a_dly_cmd: assert property (act_valid |=> res.dly_cmd == $past(act.rw_cmd[3:2])) // [R2]
        else $error("delay command not passed");
    a_seq_clear: assert property (act_valid && act.rw_cmd[5] |=> res.rw_out[5:4] == 2'h0) // [R4]
        else $error("sequence bits not cleared");
    a_dmac_copy: assert property (act_valid && act.rw_cmd[6] && act.rt_mode == 4'h0 // [R5]
        && !act.mac_swap |=> res.dmac == $past(frm.smac))
        else $error("dmac not copied from smac");
    a_hop_dec: assert property (act_valid && act.hop_upd && !act.rt_mode[3] // [R7]
        |=> res.hop == AAD_HOP_DEC)
        else $error("hop limit not decremented");
    a_hop_preset: assert property (act_valid && act.hop_upd && act.rt_mode[3] // [R8]
        && act.rt_mode[2] && rt_gate
        |=> res.hop == AAD_HOP_SET && res.hop_val == $past(ttl_val))
        else $error("hop limit not preset");
    a_lb_gate: assert property (act_valid && act.lb_only && !frm.lb_class // [R9]
        && act.rt_mode != 4'h8 |=> !res.uc_route && !res.mc_route && !res.ip_swap)
        else $error("mode applied outside loopback class");
    a_l4_ports: assert property (act_valid && act.l4_rw // [R11]
        |=> res.dport == $past(act.lid) && res.sport == $past(act.lid_mask))
        else $error("l4 ports not rewritten");
    a_cl_rslt: assert property (act_valid && act.cpu_copy // [R12]
        |=> res.cl_rslt == $past(act.lid))
        else $error("class result missing logical id");
    a_log_sign: assert property (act_valid && act.rw_cmd[5] // [R21]
        |=> res.log_vld && (res.log_int[3] == $past(act.mac_swap)))
        else $error("log interval sign wrong");
    a_res_lat: assert property (act_valid |=> res_valid ##1 !res_valid || $past(act_valid))
        else $error("result valid latency wrong");
    a_bus_resp: assert property (wr_go
        |=> bvalid && bresp == ($past(wr_hit) ? `AAD_RESP_OK : `AAD_RESP_ERR))
        else $error("write response not raised");

    c_swap_ip: cover property (act_valid && act.rt_mode == 4'hc);
    c_dpart: cover property (act_valid && dpart);
    c_sip_wr: cover property (wr_sip);
    c_cnt_rd: cover property (rd_go && ra_cval);
endmodule

// *** inc/aad_regs.svh ***
// register offsets, field positions and reset values of the action decoder
`ifndef AAD_REGS_SVH
`define AAD_REGS_SVH
`define AAD_AW 8
`define AAD_IPSC_OFS 8'h00
`define AAD_CIDX_OFS 8'h04
`define AAD_CVAL_OFS 8'h08
`define AAD_STAT_OFS 8'h0c
`define AAD_SIP_BASE 8'h80
`define AAD_IPSC_RST 32'h0000_3000
`define AAD_IPSC_MASK 32'h0000_3fff
`define AAD_TTL_LSB 0
`define AAD_BITS_LSB 8
`define AAD_RT_DPART 4'h8
`define AAD_MAC_MC 40
`define AAD_MAC_W 48
`define AAD_RESP_OK 2'b00
`define AAD_RESP_ERR 2'b10
`endif

// *** inc/aad_pkg.sv ***
// types shared by the action decoder files
package aad_pkg;
    typedef enum logic [2:0] {
        AAD_HOP_NONE = 3'b001,
        AAD_HOP_DEC = 3'b010,
        AAD_HOP_SET = 3'b100
    } aad_hop_t;

    typedef struct packed {
        logic [7:0] rw_cmd;
        logic hop_upd;
        logic lb_only;
        logic l4_rw;
        logic [15:0] lid;
        logic [15:0] lid_mask;
        logic [11:0] hit_idx;
        logic mac_swap;
        logic [2:0] log_code;
        logic [3:0] rt_mode;
        logic [47:0] repl_mac;
        logic [1:0] dom_sel;
        logic cpu_copy;
        logic [4:0] pol_idx;
    } aad_action_t;

    typedef struct packed {
        logic [47:0] dmac;
        logic [47:0] smac;
        logic [47:0] egr_smac;
        logic dip_mc;
        logic lb_class;
    } aad_frame_t;

    typedef struct packed {
        logic [1:0] ptp_cmd;
        logic [1:0] dly_cmd;
        logic [1:0] seq_cmd;
        logic [7:0] rw_out;
        logic [47:0] dmac;
        logic [47:0] smac;
        logic ip_swap;
        logic sip_repl;
        logic [31:0] sip;
        aad_hop_t hop;
        logic [7:0] hop_val;
        logic uc_route;
        logic mc_route;
        logic mac_ovl;
        logic pt_ovr;
        logic [5:0] pt_idx;
        logic dlb_en;
        logic [9:0] dlb_idx;
        logic l4_rw;
        logic [15:0] dport;
        logic [15:0] sport;
        logic [15:0] cl_rslt;
        logic [1:0] dom_sel;
        logic log_vld;
        logic [3:0] log_int;
        logic [11:0] hit_idx;
    } aad_result_t;
endpackage

// *** design/aad_mac_merge.sv ***
// replaces the top nbits of a MAC address, counted from the MSB
`timescale 1ns/100ps
module aad_mac_merge #(
    parameter int W = 48
) (
    input wire logic [W-1:0] orig,
    input wire logic [W-1:0] repl,
    input wire logic [6:0] nbits,
    output logic [W-1:0] merged
);
    generate
        if (W < 1 || W > 127) begin : g_chk
            $error("aad_mac_merge: W out of range");
        end
        for (genvar i = 0; i < W; i++) begin : g_bit
            assign merged[i] = (7'(W - 1 - i) < nbits) ? repl[i] : orig[i];
        end
    endgenerate
endmodule

// *** design/aad_frame_counter_table.sv ***
// frame counter table, one increment port and one software port
`timescale 1ns/100ps
module aad_frame_counter_table #(
    parameter int N = 4096,
    parameter int AW = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic inc,
    input wire logic [AW-1:0] inc_idx,
    input wire logic clr,
    input wire logic [AW-1:0] clr_idx,
    input wire logic [AW-1:0] rd_idx,
    output logic [31:0] rd_cnt
);
    logic [31:0] cnt_mem [N];
    wire clr_hit = clr && (clr_idx == inc_idx);

    generate
        if (N < 2 || (1 << AW) != N) begin : g_chk
            $error("aad_frame_counter_table: N must be 2**AW");
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < N; i++) begin
                cnt_mem[i] <= 32'h0;
            end
        end else begin
            if (clr) begin
                cnt_mem[clr_idx] <= 32'h0;
            end
            // a hit in the clearing cycle still counts
            if (inc) begin
                cnt_mem[inc_idx] <= clr_hit ? 32'h1 : cnt_mem[inc_idx] + 32'h1;
            end
        end
    end

    assign rd_cnt = cnt_mem[rd_idx];
endmodule

// *** verif/aad_lookup_model.sv ***
// rule lookup stage model: hands one action and its frame to the decoder
`timescale 1ns/100ps
module aad_lookup_model
    import aad_pkg::*;
(
    input wire logic aclk,
    output logic act_valid,
    output aad_action_t act,
    output aad_frame_t frm
);
    initial begin
        act_valid = 1'b0;
        act = '0;
        frm = '0;
    end
    // ============================================================
    // one action per call; call right after a rising edge
    task automatic send(input aad_action_t a, input aad_frame_t f);
        act_valid <= 1'b1;
        act <= a;
        frm <= f;
        @(posedge aclk);
        act_valid <= 1'b0;
        // idle bus shows the inverse, so a stale word is never mistaken for a live one
        act <= ~a;
        frm <= ~f;
    endtask
endmodule

// *** verif/aad_action_decoder_tb.sv ***
// self-checking testbench of the action decoder
`timescale 1ns/100ps
module aad_action_decoder_tb;
    import aad_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, res_valid, act_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, seed, ipsc, d;
    logic [1:0] r;
    aad_action_t act, a;
    aad_frame_t frm, f;
    aad_result_t res;
    int num_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n_act = 0;

    always #50 aclk = ~aclk;

    aad_lookup_model lk (.aclk(aclk), .act_valid(act_valid), .act(act), .frm(frm));

    aad_action_decoder #(.CNT_N(16), .SIP_N(32)) uut (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .act_valid(act_valid), .act(act), .frm(frm),
        .res_valid(res_valid), .res(res)
    );

    // ============================================================
    // verdict and hang guard
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // whole run needs well under 5000 cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    // don't-care fields are masked on both sides
    function automatic aad_result_t prj(aad_result_t x);
        if (x.hop != AAD_HOP_SET) x.hop_val = '0;
        if (!x.log_vld) x.log_int = '0;
        return x;
    endfunction

    task automatic chk_res(input aad_result_t got, input aad_result_t exp);
        check_count++;
        if (prj(got) !== prj(exp)) begin
            num_errors++;
            $display("ERROR %0t result got %h exp %h", $time, prj(got), prj(exp));
        end
    endtask

    // ============================================================
    // reference decode
    function automatic aad_result_t exp_dec(aad_action_t x, aad_frame_t y, logic [31:0] c);
        aad_result_t e;
        logic [47:0] t;
        logic md;
        logic mc, ipm;
        logic [2:0] s;
        e = '0;
        e.ptp_cmd = x.rw_cmd[1:0];
        e.dly_cmd = x.rw_cmd[3:2];
        e.seq_cmd = x.rw_cmd[5:4];
        e.rw_out = x.rw_cmd[5] ? {x.rw_cmd[7:6], 2'b00, x.rw_cmd[3:0]} : x.rw_cmd;
        e.dmac = x.rw_cmd[6] ? y.smac : y.dmac;
        e.smac = x.rw_cmd[7] ? y.egr_smac : y.smac;
        if (x.mac_swap && !x.rw_cmd[5]) begin
            t = e.dmac;
            e.dmac = e.smac;
            e.smac = t;
        end
        md = !x.lb_only || y.lb_class;
        s = x.rt_mode[2:0];
        mc = e.dmac[40];
        ipm = md && x.rt_mode[3] && s[2];
        if (x.rt_mode == 4'h8 && x.lb_only) begin
            for (int i = 0; i < 48; i++) begin
                if (i >= 48 - int'(c[13:8])) e.dmac[i] = x.repl_mac[i];
            end
        end else if (md && x.rt_mode[3]) begin
            if (s == 3'h0) e.dmac = x.repl_mac;
            if (s == 3'h2 || s == 3'h4 || ((s == 3'h3 || s == 3'h5) && !mc)) begin
                t = e.dmac;
                e.dmac = e.smac;
                e.smac = t;
            end
            if (s == 3'h1 || s == 3'h7 || (s >= 3'h2 && s <= 3'h5 && mc)) begin
                e.smac = x.repl_mac;
            end
        end
        if (md && !x.rt_mode[3]) begin
            e.uc_route = x.rt_mode[0];
            e.mc_route = x.rt_mode[1];
            e.mac_ovl = x.rt_mode[2];
        end
        if (md && x.rt_mode[3:2] == 2'b01) begin
            e.pt_ovr = x.repl_mac[0];
            e.pt_idx = x.repl_mac[6:1];
            e.dlb_en = x.repl_mac[16];
            e.dlb_idx = x.repl_mac[26:17];
        end
        e.ip_swap = ipm && !(s == 3'h5 && y.dip_mc);
        e.sip_repl = ipm && y.dip_mc;
        e.sip = (x.pol_idx == 5'h3) ? 32'h0a00_0003 : 32'h0;
        if (x.hop_upd && ipm) begin
            e.hop = AAD_HOP_SET;
            e.hop_val = c[7:0];
        end else begin
            e.hop = x.hop_upd ? AAD_HOP_DEC : AAD_HOP_NONE;
        end
        e.l4_rw = x.l4_rw;
        e.dport = x.l4_rw ? x.lid : 16'h0;
        e.sport = x.l4_rw ? x.lid_mask : 16'h0;
        e.cl_rslt = x.cpu_copy ? x.lid : 16'h0;
        e.dom_sel = x.dom_sel;
        e.log_vld = x.rw_cmd[5];
        e.log_int = {x.mac_swap, x.log_code};
        e.hit_idx = x.hit_idx;
        return e;
    endfunction

    // ============================================================
    // register bus and action traffic
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= ad;
        wdata <= dt;
        bready <= 1'b1;
        @(posedge aclk);
        while (!(awready && wready)) @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (!bvalid) @(posedge aclk);
        rs = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        arvalid <= 1'b1;
        araddr <= ad;
        rready <= 1'b1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        dt = rdata;
        rs = rresp;
    endtask

    task automatic rand_act(output aad_action_t x, output aad_frame_t y);
        logic [191:0] b;
        b = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        x = b[$bits(aad_action_t)-1:0];
        b = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        y = b[$bits(aad_frame_t)-1:0];
        x.rt_mode = {1'b0, x.rt_mode[2:0]};
    endtask

    task automatic run(input aad_action_t x, input aad_frame_t y);
        lk.send(x, y);
        n_act++;
        @(posedge aclk);
        chk_word({31'h0, res_valid}, 32'h1);
        chk_res(res, exp_dec(x, y, ipsc));
    endtask

    initial begin
        seed = 32'h2517;
        ipsc = 32'h0000_3000;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(8'h00, d, r);
        chk_word(d, 32'h0000_3000);
        axi_wr(8'h00, 32'hffff_ffff, r);
        axi_rd(8'h00, d, r);
        chk_word(d, 32'h0000_3fff);
        axi_wr(8'h40, 32'h1, r);
        chk_word({30'h0, r}, 32'h2);
        axi_rd(8'h44, d, r);
        chk_word({30'h0, r}, 32'h2);
        // twelve leading bits replaced, preset hop value 0x40
        ipsc = 32'h0000_0c40;
        axi_wr(8'h00, ipsc, r);
        axi_wr(8'h04, 32'h5, r);
        // source address replacement entry 3
        axi_wr(8'h8c, 32'h0a00_0003, r);
        chk_word({30'h0, r}, 32'h0);
        // two rules share counter 5, a third hits counter 6
        for (int i = 0; i < 3; i++) begin
            rand_act(a, f);
            a.hit_idx = (i == 2) ? 12'h6 : 12'h5;
            run(a, f);
        end
        axi_rd(8'h08, d, r);
        chk_word(d, 32'h2);
        axi_rd(8'h0c, d, r);
        chk_word(d, 32'h3);
        // mode corners: partial replace, gated replace, swap sub-modes 2 to 7
        for (int i = 0; i < 9; i++) begin
            rand_act(a, f);
            a.rt_mode = (i == 0) ? 4'h8 : ((i < 3) ? 4'h9 : 4'(i + 7));
            a.lb_only = (i < 3);
            a.hop_upd = 1'b1;
            f.lb_class = (i == 2);
            a.repl_mac = 48'hffff_ffff_ffff;
            if (i < 3) begin
                f.dmac = 48'h0;
                f.smac = 48'h0;
            end
            run(a, f);
        end
        rand_act(a, f);
        a.rw_cmd = 8'hff;
        a.mac_swap = 1'b1;
        run(a, f);
        repeat (200) begin
            rand_act(a, f);
            run(a, f);
        end
        axi_rd(8'h0c, d, r);
        chk_word(d, n_act);
        final_report();
    end
endmodule
